// file: line_ctrl_pkg.sv
// constants, types and functional notes for the line mode and status block
// Functional notes
// - idle keeps oscillator, stops traffic, releases transmit driver
// - activate enters active mode, driver enabled, normal traffic
// - re-arbitrate after attempt: clear retries, reselect message
// - manual command makes one diagnosis clock pulse
// - line status read only, resets to x01xxx00
// - sleeping flag bit 6, idling flag bit 5
// - reset enters idle mode with idling flag set
// - two low diagnosis bits encode communication state
// - input mismatch flag sticky until reinit or reset
// - transmitting flag from selection until success or abandon
// - receiving flag shows bus activity in active mode only
// - progress register: retries high, channel low, reset zero
// - last message low nibble holds its channel number
// - last message high nibble holds retry count at success or abandon
// - sleep stops oscillator, left by idle or activate
package line_ctrl_pkg;

    // =====================================================
    // register map
    localparam logic [7:0] ADDR_COMMAND = 8'h03;
    localparam logic [7:0] ADDR_LINE_STATE = 8'h04;
    localparam logic [7:0] ADDR_TX_PROGRESS = 8'h05;
    localparam logic [7:0] ADDR_LAST_MESSAGE = 8'h06;

    // =====================================================
    // command register bits
    localparam int CMD_GENERAL_RESET = 7;
    localparam int CMD_SLEEP = 6;
    localparam int CMD_IDLE = 5;
    localparam int CMD_ACTIVATE = 4;
    localparam int CMD_REARBITRATE = 3;
    localparam int CMD_MANUAL_DIAG_CLOCK = 0;

    // =====================================================
    // line status register bits
    localparam int LS_SLEEPING = 6;
    localparam int LS_IDLING = 5;
    localparam int LS_MISMATCH = 4;
    localparam int LS_DIAG_MID = 3;
    localparam int LS_DIAG_LOW = 2;
    localparam int LS_TRANSMITTING = 1;
    localparam int LS_RECEIVING = 0;

    // =====================================================
    // widths, reset values and timing
    localparam int NIBBLE_W = 4;
    localparam logic [3:0] NIBBLE_ZERO = 4'h0;
    localparam logic [3:0] NIBBLE_ONE = 4'h1;
    localparam logic [3:0] NIBBLE_MAX = 4'hf;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int DIAG_PULSE_TIMESLOTS = 2;
    localparam logic [1:0] DIAG_PULSE_CYCLES = 2'(DIAG_PULSE_TIMESLOTS);
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_ZERO = 2'h0;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_ACTIVE,
        MODE_SLEEP
    } mode_t;

endpackage : line_ctrl_pkg

// file: diag_link_if.sv
// carrier between the controller and its line comparison module
`timescale 1ns/1ps
interface diag_link_if;
    logic en;
    logic [2:0] lines;
    logic clear;
    logic mismatch;

    modport ctrl (output en, output lines, output clear, input mismatch);
    modport cmp (input en, input lines, input clear, output mismatch);
endinterface : diag_link_if

// file: line_compare.sv
// sticky detector of disagreement among the three line inputs
`timescale 1ns/1ps
module line_compare (
    input wire logic i_clk,
    input wire logic i_reset,
    diag_link_if.cmp link
);
    import line_ctrl_pkg::*;

    logic mismatch_q;
    logic differ;

    // =====================================================
    // comparison
    assign differ = (link.lines[0] != link.lines[1]) || (link.lines[1] != link.lines[2]);

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mismatch_q <= 1'b0;
        end
        else if (link.en)
        begin
            if (differ)
            begin
                mismatch_q <= 1'b1;
            end
            else if (link.clear)
            begin
                mismatch_q <= 1'b0;
            end
        end
    end

    assign link.mismatch = mismatch_q;

endmodule : line_compare

// file: line_mode_status.sv
// mode commands and status registers of the serial line controller
`timescale 1ns/1ps
module line_mode_status (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_ale,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_ad,
    output logic [7:0] o_ad,
    output logic o_ad_oe,
    input wire logic i_line_input_zero,
    input wire logic i_line_input_one,
    input wire logic i_line_input_two,
    input wire logic i_diag_reinit_signal,
    input wire logic [1:0] i_diag_state,
    input wire logic i_divider_diag_clock,
    input wire logic i_bus_activity,
    input wire logic i_tx_select,
    input wire logic [3:0] i_tx_channel,
    input wire logic i_attempt_fail,
    input wire logic i_attempt_end,
    input wire logic i_tx_success,
    input wire logic i_tx_abandon,
    input wire logic i_rx_success,
    input wire logic [3:0] i_rx_channel,
    output logic o_osc_run,
    output logic o_traffic_enable,
    output logic o_txd_oe,
    output logic o_rearbitrate,
    output logic o_diag_cycle_clock,
    output line_ctrl_pkg::mode_t o_mode
);
    import line_ctrl_pkg::*;

    diag_link_if link ();

    mode_t mode_q;
    logic [7:0] addr_q;
    logic wr_q;
    logic cmd_write;
    logic [7:0] cmd;
    logic soft_reset;
    logic rearb_pending_q;
    logic rearbitrate_q;
    logic [1:0] diag_pulse_q;
    logic transmitting_flag_q;
    logic receiving_flag_q;
    logic [3:0] retries_so_far_q;
    logic [3:0] current_tx_channel_q;
    logic [3:0] last_retry_count_q;
    logic [3:0] last_channel_number_q;
    logic [7:0] rdata;
    logic [7:0] ad_q;
    logic ad_oe_q;

    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] ls,
                                            input logic [7:0] tp, input logic [7:0] lm);
        case (addr)
            ADDR_LINE_STATE: reg_read = ls;
            ADDR_TX_PROGRESS: reg_read = tp;
            ADDR_LAST_MESSAGE: reg_read = lm;
            default: reg_read = BYTE_ZERO;
        endcase
    endfunction : reg_read

    // =====================================================
    // host bus: address latch and write strobe edge
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            addr_q <= BYTE_ZERO;
            wr_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (i_ale)
            begin
                addr_q <= i_ad;
            end
            wr_q <= i_wr & i_cs;
        end
    end

    assign cmd_write = i_wr & i_cs & ~wr_q & (addr_q == ADDR_COMMAND);
    assign cmd = cmd_write ? i_ad : BYTE_ZERO;
    assign soft_reset = cmd[CMD_GENERAL_RESET];

    // =====================================================
    // operating mode
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            mode_q <= MODE_IDLE;
        end
        else if (i_clk_en)
        begin
            if (soft_reset)
            begin
                mode_q <= MODE_IDLE;
            end
            else if (cmd[CMD_IDLE])
            begin
                mode_q <= MODE_IDLE;
            end
            else if (cmd[CMD_ACTIVATE])
            begin
                mode_q <= MODE_ACTIVE;
            end
            else if (cmd[CMD_SLEEP])
            begin
                mode_q <= MODE_SLEEP;
            end
        end
    end

    always_comb
    begin
        o_osc_run = 1'b1;
        o_traffic_enable = 1'b0;
        o_txd_oe = 1'b0;
        case (mode_q)
            MODE_IDLE:
            begin
                o_osc_run = 1'b1;
            end
            MODE_ACTIVE:
            begin
                o_traffic_enable = 1'b1;
                o_txd_oe = 1'b1;
            end
            MODE_SLEEP:
            begin
                o_osc_run = 1'b0;
            end
            default:
            begin
                o_osc_run = 1'b1;
            end
        endcase
    end

    assign o_mode = mode_q;

    // =====================================================
    // re-arbitration after the running attempt
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            rearb_pending_q <= 1'b0;
            rearbitrate_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            rearbitrate_q <= 1'b0;
            if (soft_reset)
            begin
                rearb_pending_q <= 1'b0;
            end
            else if (cmd[CMD_REARBITRATE])
            begin
                rearb_pending_q <= 1'b1;
            end
            else if (rearb_pending_q && (i_attempt_end || !transmitting_flag_q))
            begin
                rearb_pending_q <= 1'b0;
                rearbitrate_q <= 1'b1;
            end
        end
    end

    assign o_rearbitrate = rearbitrate_q;

    // =====================================================
    // manual diagnosis clock pulse
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            diag_pulse_q <= COUNT_ZERO;
        end
        else if (i_clk_en)
        begin
            if (soft_reset)
            begin
                diag_pulse_q <= COUNT_ZERO;
            end
            else if (cmd[CMD_MANUAL_DIAG_CLOCK])
            begin
                diag_pulse_q <= DIAG_PULSE_CYCLES;
            end
            else if (diag_pulse_q != COUNT_ZERO)
            begin
                diag_pulse_q <= diag_pulse_q - COUNT_ONE;
            end
        end
    end

    assign o_diag_cycle_clock = (diag_pulse_q != COUNT_ZERO) | i_divider_diag_clock;

    // =====================================================
    // input comparison
    assign link.en = i_clk_en;
    assign link.lines = {i_line_input_two, i_line_input_one, i_line_input_zero};
    assign link.clear = i_diag_reinit_signal | soft_reset;

    line_compare u_compare (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .link(link)
    );

    // =====================================================
    // transmitting and receiving flags
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            transmitting_flag_q <= 1'b0;
            receiving_flag_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            receiving_flag_q <= i_bus_activity & o_traffic_enable & ~soft_reset;
            if (soft_reset)
            begin
                transmitting_flag_q <= 1'b0;
            end
            else if (i_tx_select)
            begin
                transmitting_flag_q <= 1'b1;
            end
            else if (i_tx_success || i_tx_abandon)
            begin
                transmitting_flag_q <= 1'b0;
            end
        end
    end

    // =====================================================
    // retry counter and channel in transmission
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            retries_so_far_q <= NIBBLE_ZERO;
            current_tx_channel_q <= NIBBLE_ZERO;
        end
        else if (i_clk_en)
        begin
            if (soft_reset)
            begin
                retries_so_far_q <= NIBBLE_ZERO;
                current_tx_channel_q <= NIBBLE_ZERO;
            end
            else if (i_tx_select)
            begin
                retries_so_far_q <= NIBBLE_ZERO;
                current_tx_channel_q <= i_tx_channel;
            end
            else if (rearbitrate_q)
            begin
                retries_so_far_q <= NIBBLE_ZERO;
            end
            else if (i_attempt_fail && retries_so_far_q != NIBBLE_MAX)
            begin
                retries_so_far_q <= retries_so_far_q + NIBBLE_ONE;
            end
        end
    end

    // =====================================================
    // last message report
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            last_retry_count_q <= NIBBLE_ZERO;
            last_channel_number_q <= NIBBLE_ZERO;
        end
        else if (i_clk_en)
        begin
            if (soft_reset)
            begin
                last_retry_count_q <= NIBBLE_ZERO;
                last_channel_number_q <= NIBBLE_ZERO;
            end
            else if (i_tx_success || i_tx_abandon)
            begin
                last_retry_count_q <= retries_so_far_q;
                last_channel_number_q <= current_tx_channel_q;
            end
            else if (i_rx_success)
            begin
                last_channel_number_q <= i_rx_channel;
            end
        end
    end

    // =====================================================
    // register read port
    always_comb
    begin
        logic [7:0] ls;
        ls = BYTE_ZERO;
        ls[LS_SLEEPING] = (mode_q == MODE_SLEEP);
        ls[LS_IDLING] = (mode_q == MODE_IDLE);
        ls[LS_MISMATCH] = link.mismatch;
        ls[LS_DIAG_MID] = i_diag_state[1];
        ls[LS_DIAG_LOW] = i_diag_state[0];
        ls[LS_TRANSMITTING] = transmitting_flag_q;
        ls[LS_RECEIVING] = receiving_flag_q;
        rdata = reg_read(addr_q, ls, {retries_so_far_q, current_tx_channel_q},
                         {last_retry_count_q, last_channel_number_q});
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            ad_q <= BYTE_ZERO;
            ad_oe_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            ad_oe_q <= i_rd & i_cs & ~i_ale;
            if (i_rd && i_cs)
            begin
                ad_q <= rdata;
            end
        end
    end

    assign o_ad = ad_q;
    assign o_ad_oe = ad_oe_q;

endmodule : line_mode_status

// file: lms_properties.sv
// checker of the line mode and status block ports
`timescale 1ns/1ps
module lms_checker
    import line_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_clk_en,
    input wire logic i_ale,
    input wire logic i_cs,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_ad,
    input wire logic i_divider_diag_clock,
    input wire logic o_ad_oe,
    input wire logic o_osc_run,
    input wire logic o_traffic_enable,
    input wire logic o_txd_oe,
    input wire logic o_rearbitrate,
    input wire logic o_diag_cycle_clock,
    input wire line_ctrl_pkg::mode_t o_mode
);
    // ==========================================
    // helper: latched address and write edge
    logic [7:0] addr_q;
    logic wr_seen_q;
    logic cmd_wr;
    always_ff @(posedge i_clk or posedge i_reset)
        if (i_reset) addr_q <= 8'h00;
        else if (i_clk_en && i_ale) addr_q <= i_ad;
    always_ff @(posedge i_clk or posedge i_reset)
        if (i_reset) wr_seen_q <= 1'b0;
        else if (i_clk_en) wr_seen_q <= i_wr && i_cs;
    assign cmd_wr = i_clk_en && i_wr && i_cs && !wr_seen_q && addr_q == ADDR_COMMAND;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // ==========================================
    // assertions
    idle_quiet_a: assert property
        (o_mode == MODE_IDLE |-> !o_txd_oe && !o_traffic_enable && o_osc_run)
        else $error("idle mode drives the line");
    active_drive_a: assert property
        (o_mode == MODE_ACTIVE |-> o_txd_oe && o_traffic_enable)
        else $error("active mode without driver");
    sleep_osc_a: assert property
        (o_osc_run == (o_mode != MODE_SLEEP))
        else $error("oscillator run does not match mode");
    idle_cmd_a: assert property
        (cmd_wr && i_ad[CMD_IDLE] |=> o_mode == MODE_IDLE)
        else $error("idle command ignored");
    activate_cmd_a: assert property
        (cmd_wr && i_ad[CMD_ACTIVATE] && !i_ad[CMD_IDLE] && !i_ad[CMD_GENERAL_RESET]
            |=> o_mode == MODE_ACTIVE)
        else $error("activate command ignored");
    mode_hold_a: assert property
        (i_clk_en && !cmd_wr |=> $stable(o_mode))
        else $error("mode changed without command");
    rearb_single_a: assert property
        (o_rearbitrate && i_clk_en |=> !o_rearbitrate)
        else $error("rearbitrate pulse too long");
    manual_pulse_a: assert property
        (cmd_wr && i_ad[CMD_MANUAL_DIAG_CLOCK] && !i_ad[CMD_GENERAL_RESET] && !i_divider_diag_clock
            |=> o_diag_cycle_clock [*2] ##1 !o_diag_cycle_clock)
        else $error("manual diagnosis pulse not two cycles");
    read_drive_a: assert property
        (i_clk_en && i_rd && i_cs && !i_ale |=> o_ad_oe ##1 (o_ad_oe == $past(i_rd)))
        else $error("read data not driven");
    cover property (o_rearbitrate);
    cover property (o_mode == MODE_SLEEP);
    cover property ($rose(o_diag_cycle_clock));
endmodule : lms_checker

bind line_mode_status lms_checker u_chk (.i_clk, .i_reset, .i_clk_en, .i_ale, .i_cs, .i_rd,
    .i_wr, .i_ad, .i_divider_diag_clock, .o_ad_oe, .o_osc_run, .o_traffic_enable, .o_txd_oe,
    .o_rearbitrate, .o_diag_cycle_clock, .o_mode);

// file: line_model.sv
// line side model: three line inputs and frame engine events
`timescale 1ns/1ps
module line_model (
    input wire logic i_clk,
    output logic [2:0] o_lines,
    output logic o_activity,
    output logic o_select,
    output logic [3:0] o_channel,
    output logic o_fail,
    output logic o_end,
    output logic o_success,
    output logic o_abandon,
    output logic o_rx,
    output logic [3:0] o_rx_channel
);
    // ==========================================
    // event tasks, all launched at the falling edge
    initial
    begin
        {o_lines, o_activity, o_select, o_fail, o_end, o_success, o_abandon, o_rx} = 10'h000;
        o_channel = 4'ha;
        o_rx_channel = 4'h5;
    end
    task select(input logic [3:0] ch);
        @(negedge i_clk);
        o_select = 1'b1;
        o_channel = ch;
        @(negedge i_clk);
        o_select = 1'b0;
        o_channel = ~ch;
    endtask : select
    task fail(input int n);
        @(negedge i_clk);
        o_fail = 1'b1;
        repeat (n) @(negedge i_clk);
        o_fail = 1'b0;
    endtask : fail
    task finish(input logic [1:0] kind);
        @(negedge i_clk);
        o_end = 1'b1;
        {o_abandon, o_success} = kind;
        @(negedge i_clk);
        {o_end, o_abandon, o_success} = 3'h0;
    endtask : finish
    task receive(input logic [3:0] ch);
        @(negedge i_clk);
        o_rx = 1'b1;
        o_rx_channel = ch;
        @(negedge i_clk);
        o_rx = 1'b0;
        o_rx_channel = ~ch;
    endtask : receive
    task set_lines(input logic [2:0] v, input logic a);
        @(negedge i_clk);
        o_lines = v;
        o_activity = a;
    endtask : set_lines
endmodule : line_model

// file: testbench.sv
// self-checking bench of the line mode and status block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    import line_ctrl_pkg::*;
    logic i_clk, i_reset, i_ale, i_cs, i_rd, i_wr, i_diag_reinit_signal, i_divider_diag_clock;
    logic [7:0] i_ad, o_ad, exp_v;
    logic [1:0] i_diag_state;
    logic [2:0] lines;
    logic o_ad_oe, o_osc_run, o_rearbitrate, o_diag_cycle_clock, i_bus_activity, i_tx_select;
    logic i_clk_en, o_traffic_enable, o_txd_oe;
    logic i_attempt_fail, i_attempt_end, i_tx_success, i_tx_abandon, i_rx_success;
    logic [3:0] i_tx_channel, i_rx_channel, ch;
    mode_t o_mode;
    logic [7:0] q[$];
    int n_fail = 0, num_checks = 0, cycles = 0, n_rearb = 0, n_diag = 0, seed = 82, n, k;
    // ==========================================
    // clock, parts and monitors
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    line_model u_line (.i_clk, .o_lines(lines), .o_activity(i_bus_activity),
        .o_select(i_tx_select), .o_channel(i_tx_channel), .o_fail(i_attempt_fail),
        .o_end(i_attempt_end), .o_success(i_tx_success), .o_abandon(i_tx_abandon),
        .o_rx(i_rx_success), .o_rx_channel(i_rx_channel));
    line_mode_status u_dut (.i_clk, .i_reset, .i_clk_en, .i_ale, .i_cs, .i_rd, .i_wr,
        .i_ad, .o_ad, .o_ad_oe, .i_line_input_zero(lines[0]), .i_line_input_one(lines[1]),
        .i_line_input_two(lines[2]), .i_diag_reinit_signal, .i_diag_state,
        .i_divider_diag_clock, .i_bus_activity, .i_tx_select, .i_tx_channel, .i_attempt_fail,
        .i_attempt_end, .i_tx_success, .i_tx_abandon, .i_rx_success, .i_rx_channel,
        .o_osc_run, .o_traffic_enable, .o_txd_oe, .o_rearbitrate, .o_diag_cycle_clock,
        .o_mode);
    always @(posedge i_clk)
    begin
        cycles++;
        n_rearb += (o_rearbitrate === 1'b1);
        n_diag += (o_diag_cycle_clock === 1'b1);
        if (cycles == 5000)
        begin
            n_fail++;
            test_done();
        end
    end
    always @(negedge i_clk)
        if (o_ad_oe === 1'b1)
        begin
            exp_v = q.pop_front();
            `CHK(o_ad, exp_v)
        end
    // ==========================================
    // host bus tasks
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {i_ale, i_ad} = {1'b1, a};
        @(negedge i_clk);
        {i_ale, i_cs, i_wr, i_ad} = {3'b011, d};
        @(negedge i_clk);
        {i_cs, i_wr, i_ad} = {2'b00, ~d};
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        {i_ale, i_ad} = {1'b1, a};
        @(negedge i_clk);
        {i_ale, i_cs, i_rd, i_ad} = {3'b011, ~a};
        q.push_back(e);
        @(negedge i_clk);
        {i_cs, i_rd} = 2'b00;
        @(negedge i_clk);
    endtask : rd
    task test_done();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    // ==========================================
    // scenarios
    initial
    begin
        {i_reset, i_ale, i_cs, i_rd, i_wr, i_diag_reinit_signal, i_divider_diag_clock} = 7'h40;
        {i_ad, i_diag_state} = 10'h0;
        i_clk_en = 1'b1;
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        rd(8'h04, 8'h20);
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        for (k = 0; k < 4; k++)
        begin
            i_diag_state = 2'(k);
            rd(8'h04, 8'h20 | 8'(k << 2));
        end
        i_diag_state = 2'h0;
        u_line.set_lines(3'b010, 1'b0);
        u_line.set_lines(3'b000, 1'b0);
        rd(8'h04, 8'h30);
        i_diag_reinit_signal = 1'b1;
        @(negedge i_clk);
        i_diag_reinit_signal = 1'b0;
        rd(8'h04, 8'h20);
        wr(8'h03, 8'h00);
        rd(8'h04, 8'h20);
        wr(8'h03, 8'h10);
        rd(8'h04, 8'h00);
        `CHK(o_txd_oe, 1'b1)
        `CHK(o_traffic_enable, 1'b1)
        for (k = 0; k < 2; k++)
        begin
            ch = 4'($random(seed));
            n = 1 + ($random(seed) & 3);
            u_line.select(ch);
            rd(8'h04, 8'h02);
            rd(8'h05, {4'h0, ch});
            u_line.fail(n);
            rd(8'h05, {4'(n), ch});
            u_line.finish(2'(1 << k));
            rd(8'h06, {4'(n), ch});
            rd(8'h04, 8'h00);
        end
        u_line.set_lines(3'b000, 1'b1);
        rd(8'h04, 8'h01);
        u_line.receive(4'hc);
        u_line.set_lines(3'b000, 1'b0);
        rd(8'h06, {4'(n), 4'hc});
        u_line.select(4'h9);
        u_line.fail(2);
        wr(8'h03, 8'h08);
        repeat (3) @(negedge i_clk);
        `CHK(n_rearb, 0)
        u_line.finish(2'b00);
        repeat (3) @(negedge i_clk);
        `CHK(n_rearb, 1)
        rd(8'h05, 8'h09);
        // frozen clock enable: failed attempts must not count
        i_clk_en = 1'b0;
        u_line.fail(1 + ($random(seed) & 3));
        i_clk_en = 1'b1;
        rd(8'h05, 8'h09);
        u_line.finish(2'b01);
        n_diag = 0;
        wr(8'h03, 8'h01);
        repeat (4) @(negedge i_clk);
        `CHK(n_diag, 2)
        i_divider_diag_clock = 1'b1;
        @(posedge i_clk);
        `CHK(o_diag_cycle_clock, 1'b1)
        @(negedge i_clk);
        i_divider_diag_clock = 1'b0;
        wr(8'h03, 8'h20);
        rd(8'h04, 8'h20);
        `CHK(o_txd_oe, 1'b0)
        `CHK(o_traffic_enable, 1'b0)
        `CHK(o_mode, MODE_IDLE)
        wr(8'h03, 8'h40);
        rd(8'h04, 8'h40);
        `CHK(o_osc_run, 1'b0)
        wr(8'h03, 8'h10);
        rd(8'h04, 8'h00);
        wr(8'h03, 8'h80);
        rd(8'h04, 8'h20);
        rd(8'h06, 8'h00);
        test_done();
    end
endmodule : testbench
